// ==== hdl/ssc_pkg.sv ====
// constants and types shared by the step configuration register bank
package ssc_pkg;

    // register addresses, step ten in entry 0, step eleven in entry 1
    localparam int SSC_STEP_COUNT = 2;
    localparam logic [7:0] SSC_STEP_TEN_ADDR = 8'h9a;
    localparam logic [7:0] SSC_STEP_ELEVEN_ADDR = 8'h9b;
    localparam logic [1:0][7:0] SSC_STEP_ADDR = {SSC_STEP_ELEVEN_ADDR, SSC_STEP_TEN_ADDR};

    // reset values of the two step words
    localparam logic [15:0] SSC_STEP_TEN_RESET = 16'h000a;
    localparam logic [15:0] SSC_STEP_ELEVEN_RESET = 16'h000b;
    localparam logic [1:0][15:0] SSC_STEP_RESET = {SSC_STEP_ELEVEN_RESET, SSC_STEP_TEN_RESET};

    // field positions and the mask of bits that software can change
    localparam int SSC_ENABLE_BIT = 15;
    localparam int SSC_GAIN_HI = 14;
    localparam int SSC_GAIN_LO = 13;
    localparam int SSC_RSVD_HI = 12;
    localparam int SSC_RSVD_LO = 5;
    localparam int SSC_NEG_BIT = 4;
    localparam int SSC_POS_HI = 3;
    localparam logic [15:0] SSC_WRITABLE_MASK = 16'he01f;

    // gain codes and the gain factor that each gives
    localparam logic [1:0] SSC_GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] SSC_GAIN_CODE_X2 = 2'h1;
    localparam logic [2:0] SSC_FACTOR_X1 = 3'h1;
    localparam logic [2:0] SSC_FACTOR_X2 = 3'h2;
    localparam logic [2:0] SSC_FACTOR_X4 = 3'h4;

    // positive input codes with a fixed internal meaning
    localparam logic [3:0] SSC_POS_FIRST_INTERNAL = 4'h8;
    localparam logic [3:0] SSC_POS_TEMP = 4'h8;
    localparam logic [3:0] SSC_POS_SHORT = 4'h9;
    localparam logic [3:0] SSC_POS_TEST_DAC = 4'ha;
    localparam logic [3:0] SSC_POS_ANALOG_POWER = 4'he;
    localparam logic [3:0] SSC_POS_DIGITAL_POWER = 4'hf;

    // where the converter's positive input comes from
    typedef enum logic [2:0] {
        SRC_EXTERNAL = 3'h0,
        SRC_TEMP_SENSOR = 3'h1,
        SRC_SHORT_TO_GROUND = 3'h2,
        SRC_TEST_DAC = 3'h3,
        SRC_ANALOG_POWER = 3'h4,
        SRC_DIGITAL_POWER = 3'h5,
        SRC_OTHER_INTERNAL = 3'h6
    } ssc_src_t;

    // where the converter's negative input comes from
    typedef enum logic [1:0] {
        NEG_ANALOG_GROUND = 2'h0,
        NEG_EXTERNAL_SEVEN = 2'h1,
        NEG_AUTOMATIC = 2'h2
    } ssc_neg_t;

    // one step word as stored, laid out bit for bit as software sees it
    typedef struct packed {
        logic enable;
        logic [1:0] gainSelect;
        logic [7:0] reserved;
        logic negativeInput;
        logic [3:0] positiveInput;
    } ssc_step_cfg_t;

    // the decoded routing that the sequencer applies while running a step
    typedef struct packed {
        logic enable;
        logic [2:0] gainFactor;
        ssc_src_t source;
        logic [2:0] externalIndex;
        ssc_neg_t negative;
    } ssc_route_t;

    // decoded routing of each step word at its reset value
    localparam ssc_route_t SSC_TEN_ROUTE_RESET = '{1'b0, 3'h1, SRC_TEST_DAC, 3'h2, NEG_AUTOMATIC};
    localparam ssc_route_t SSC_ELEVEN_ROUTE_RESET = '{1'b0, 3'h1, SRC_OTHER_INTERNAL, 3'h3, NEG_AUTOMATIC};
    localparam ssc_route_t [1:0] SSC_ROUTE_RESET = {SSC_ELEVEN_ROUTE_RESET, SSC_TEN_ROUTE_RESET};

endpackage

// ==== hdl/ssc_step_decode.sv ====
// decodes one stored step word into the routing the sequencer applies
`timescale 1ns/100ps
`default_nettype none
module ssc_step_decode (
    input wire ssc_pkg::ssc_step_cfg_t cfg, // stored step word
    output var ssc_pkg::ssc_route_t route // decoded routing
);

    // gain, source and negative input; internal sources pick their own negative
    always_comb begin
        route.enable = cfg.enable;
        unique case (cfg.gainSelect)
            ssc_pkg::SSC_GAIN_CODE_X1: route.gainFactor = ssc_pkg::SSC_FACTOR_X1;
            ssc_pkg::SSC_GAIN_CODE_X2: route.gainFactor = ssc_pkg::SSC_FACTOR_X2;
            default: route.gainFactor = ssc_pkg::SSC_FACTOR_X4; // both upper codes give four
        endcase
        route.externalIndex = cfg.positiveInput[2:0];
        if (cfg.positiveInput < ssc_pkg::SSC_POS_FIRST_INTERNAL) begin
            route.source = ssc_pkg::SRC_EXTERNAL;
            route.negative = cfg.negativeInput ? ssc_pkg::NEG_EXTERNAL_SEVEN : ssc_pkg::NEG_ANALOG_GROUND;
        end else begin
            route.negative = ssc_pkg::NEG_AUTOMATIC; // negative select bit ignored here
            unique case (cfg.positiveInput)
                ssc_pkg::SSC_POS_TEMP: route.source = ssc_pkg::SRC_TEMP_SENSOR;
                ssc_pkg::SSC_POS_SHORT: route.source = ssc_pkg::SRC_SHORT_TO_GROUND;
                ssc_pkg::SSC_POS_TEST_DAC: route.source = ssc_pkg::SRC_TEST_DAC;
                ssc_pkg::SSC_POS_ANALOG_POWER: route.source = ssc_pkg::SRC_ANALOG_POWER;
                ssc_pkg::SSC_POS_DIGITAL_POWER: route.source = ssc_pkg::SRC_DIGITAL_POWER;
                default: route.source = ssc_pkg::SRC_OTHER_INTERNAL;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== hdl/ssc_step_config.sv ====
// register bank holding the step ten and step eleven sequencer configuration
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config (
    input wire logic clock, // 20 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic [7:0] address, // register address
    input wire logic [15:0] writeData, // data for a write
    input wire logic writeStrobe, // one-cycle write request
    input wire logic readStrobe, // one-cycle read request
    output logic [15:0] readData, // read answer, valid the cycle after the strobe
    output var ssc_pkg::ssc_route_t stepTenRoute, // routing applied during step ten
    output var ssc_pkg::ssc_route_t stepElevenRoute // routing applied during step eleven
);

    ssc_pkg::ssc_step_cfg_t stepCfg [ssc_pkg::SSC_STEP_COUNT];
    ssc_pkg::ssc_route_t decodedRoute [ssc_pkg::SSC_STEP_COUNT];
    ssc_pkg::ssc_route_t routeReg [ssc_pkg::SSC_STEP_COUNT];
    logic [ssc_pkg::SSC_STEP_COUNT-1:0] addressHit;
    logic [15:0] next_readData;

    // one storage word, one decoder and one routing register per step
    for (genvar i = 0; i < ssc_pkg::SSC_STEP_COUNT; i++) begin : gen_step
        assign addressHit[i] = (address == ssc_pkg::SSC_STEP_ADDR[i]);

        // the word; reserved bits are masked off so they can never store ones
        always_ff @(posedge clock) begin
            if (reset) begin
                stepCfg[i] <= ssc_pkg::ssc_step_cfg_t'(ssc_pkg::SSC_STEP_RESET[i]);
            end else if (writeStrobe && addressHit[i]) begin
                stepCfg[i] <= ssc_pkg::ssc_step_cfg_t'(writeData & ssc_pkg::SSC_WRITABLE_MASK);
            end
        end

        ssc_step_decode u_decode (
            .cfg(stepCfg[i]),
            .route(decodedRoute[i])
        );

        // registered routing, so the analog side sees glitch-free selects
        always_ff @(posedge clock) begin
            if (reset) begin
                routeReg[i] <= ssc_pkg::SSC_ROUTE_RESET[i];
            end else begin
                routeReg[i] <= decodedRoute[i];
            end
        end
    end

    assign stepTenRoute = routeReg[0];
    assign stepElevenRoute = routeReg[1];

    // read mux; unmapped addresses and idle cycles answer zero
    always_comb begin
        next_readData = 16'h0000;
        for (int k = 0; k < ssc_pkg::SSC_STEP_COUNT; k++) begin
            if (readStrobe && addressHit[k]) begin
                next_readData = stepCfg[k] & ssc_pkg::SSC_WRITABLE_MASK;
            end
        end
    end

    // read data stand for exactly one cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            readData <= 16'h0000;
        end else begin
            readData <= next_readData;
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence seqTenWrite;
        writeStrobe && address == ssc_pkg::SSC_STEP_TEN_ADDR;
    endsequence

    sequence seqTenRead;
        readStrobe && address == ssc_pkg::SSC_STEP_TEN_ADDR;
    endsequence

    sequence seqElevenRead;
        readStrobe && address == ssc_pkg::SSC_STEP_ELEVEN_ADDR;
    endsequence

    // write lands at the next edge, the routing one edge later
    sequence seqTenSettled;
        ##2 1'b1;
    endsequence

    property propEnableFollows;
        seqTenWrite |-> seqTenSettled ##0 (stepTenRoute.enable == $past(writeData[15], 2));
    endproperty

    AST_ENABLE_FOLLOWS: assert property (propEnableFollows)
        else $error("step ten enable does not follow the written bit");

    // gain code decoded by hand here so a decoder slip cannot hide
    AST_GAIN_FACTOR: assert property (
        seqTenWrite |-> ##2 (stepTenRoute.gainFactor ==
            ($past(writeData[14:13], 2) == 2'h0 ? 3'h1 : $past(writeData[14:13], 2) == 2'h1 ? 3'h2 : 3'h4)))
        else $error("step ten gain factor wrong for written code");

    // reserved field reads zero for both words
    AST_RESERVED_ZERO: assert property (
        (seqTenRead or seqElevenRead) |=> readData[12:5] == 8'h00)
        else $error("reserved bits read as nonzero");

    // external codes honour the negative select bit
    AST_NEGATIVE_EXTERNAL: assert property (
        seqTenWrite ##0 (writeData[3:0] < ssc_pkg::SSC_POS_FIRST_INTERNAL) |-> ##2
            (stepTenRoute.negative == (($past(writeData[4], 2)) ? ssc_pkg::NEG_EXTERNAL_SEVEN
                                                                 : ssc_pkg::NEG_ANALOG_GROUND)))
        else $error("step ten negative input does not follow its select bit");

    // external codes pass their low three bits through as the input index
    AST_POSITIVE_EXTERNAL: assert property (
        seqTenWrite ##0 (writeData[3:0] < ssc_pkg::SSC_POS_FIRST_INTERNAL) |-> ##2
            (stepTenRoute.source == ssc_pkg::SRC_EXTERNAL && stepTenRoute.externalIndex == $past(writeData[2:0], 2)))
        else $error("step ten external input index wrong");

    // the three named internal sources
    AST_INTERNAL_SOURCE: assert property (
        seqTenWrite ##0 (writeData[3:0] inside {4'h8, 4'h9, 4'ha}) |-> ##2
            (stepTenRoute.source == ($past(writeData[3:0], 2) == 4'h8 ? ssc_pkg::SRC_TEMP_SENSOR :
                                     $past(writeData[3:0], 2) == 4'h9 ? ssc_pkg::SRC_SHORT_TO_GROUND :
                                                                        ssc_pkg::SRC_TEST_DAC)))
        else $error("step ten internal source wrong");

    // the two supply monitors sit at the top two codes
    AST_SUPPLY_MONITOR: assert property (
        seqTenWrite ##0 (writeData[3:1] == 3'h7) |-> ##2
            (stepTenRoute.source == ($past(writeData[0], 2) ? ssc_pkg::SRC_DIGITAL_POWER
                                                            : ssc_pkg::SRC_ANALOG_POWER)))
        else $error("step ten supply monitor selection wrong");

    // routing lags the stored word by one edge, hence the past value
    AST_AUTO_NEGATIVE: assert property (
        $past(stepCfg[0].positiveInput) >= ssc_pkg::SSC_POS_FIRST_INTERNAL && !$past(reset) |->
            stepTenRoute.negative == ssc_pkg::NEG_AUTOMATIC)
        else $error("negative select bit not ignored for internal source");

    // first edge after reset shows both reset words and step ten's reset routing
    AST_RESET_VALUES: assert property (
        $past(reset) |-> stepTenRoute.source == ssc_pkg::SRC_TEST_DAC && !stepTenRoute.enable
            && stepCfg[0] == ssc_pkg::ssc_step_cfg_t'(ssc_pkg::SSC_STEP_TEN_RESET)
            && stepCfg[1] == ssc_pkg::ssc_step_cfg_t'(ssc_pkg::SSC_STEP_ELEVEN_RESET))
        else $error("step words or routing wrong after reset");

    // a read straight after a write returns the new value
    AST_TEN_READBACK: assert property (
        seqTenWrite ##1 seqTenRead |=> readData == ($past(writeData, 2) & ssc_pkg::SSC_WRITABLE_MASK))
        else $error("step ten read back differs from written value");

    AST_ELEVEN_READBACK: assert property (
        seqElevenRead |=> readData == ($past(stepCfg[1]) & ssc_pkg::SSC_WRITABLE_MASK))
        else $error("step eleven read back differs from stored value");

    // read data is a pulse, so a stale answer can never be mistaken for a new one
    AST_IDLE_ZERO: assert property (
        !readStrobe |=> readData == 16'h0000)
        else $error("read data not zero outside the answer cycle");

    // step eleven has its own decoder instance; these catch a slip in its own wiring
    sequence seqElevenWrite;
        writeStrobe && address == ssc_pkg::SSC_STEP_ELEVEN_ADDR;
    endsequence

    // accesses that hit neither word must leave no trace
    sequence seqStrayWrite;
        writeStrobe && address != ssc_pkg::SSC_STEP_TEN_ADDR && address != ssc_pkg::SSC_STEP_ELEVEN_ADDR;
    endsequence

    sequence seqStrayRead;
        readStrobe && address != ssc_pkg::SSC_STEP_TEN_ADDR && address != ssc_pkg::SSC_STEP_ELEVEN_ADDR;
    endsequence

    // enable bit of step eleven, same two-edge latency as step ten
    AST_ELEVEN_ENABLE: assert property (
        seqElevenWrite |-> seqTenSettled ##0 (stepElevenRoute.enable == $past(writeData[15], 2)))
        else $error("step eleven enable does not follow the written bit");

    // gain of step eleven
    AST_ELEVEN_GAIN: assert property (
        seqElevenWrite |-> ##2 (stepElevenRoute.gainFactor ==
            ($past(writeData[14:13], 2) == 2'h0 ? 3'h1 : $past(writeData[14:13], 2) == 2'h1 ? 3'h2 : 3'h4)))
        else $error("step eleven gain factor wrong for written code");

    // negative select of step eleven on external codes
    AST_ELEVEN_NEGATIVE: assert property (
        seqElevenWrite ##0 (writeData[3:0] < ssc_pkg::SSC_POS_FIRST_INTERNAL) |-> ##2
            (stepElevenRoute.negative == (($past(writeData[4], 2)) ? ssc_pkg::NEG_EXTERNAL_SEVEN
                                                                    : ssc_pkg::NEG_ANALOG_GROUND)))
        else $error("step eleven negative input does not follow its select bit");

    // external input index of step eleven
    AST_ELEVEN_POSITIVE: assert property (
        seqElevenWrite ##0 (writeData[3:0] < ssc_pkg::SSC_POS_FIRST_INTERNAL) |-> ##2
            (stepElevenRoute.source == ssc_pkg::SRC_EXTERNAL
                && stepElevenRoute.externalIndex == $past(writeData[2:0], 2)))
        else $error("step eleven external input index wrong");

    // internal sources of step eleven
    AST_ELEVEN_INTERNAL: assert property (
        seqElevenWrite ##0 (writeData[3:0] inside {4'h8, 4'h9, 4'ha}) |-> ##2
            (stepElevenRoute.source == ($past(writeData[3:0], 2) == 4'h8 ? ssc_pkg::SRC_TEMP_SENSOR :
                                        $past(writeData[3:0], 2) == 4'h9 ? ssc_pkg::SRC_SHORT_TO_GROUND :
                                                                           ssc_pkg::SRC_TEST_DAC)))
        else $error("step eleven internal source wrong");

    // supply monitors of step eleven
    AST_ELEVEN_SUPPLY: assert property (
        seqElevenWrite ##0 (writeData[3:1] == 3'h7) |-> ##2
            (stepElevenRoute.source == ($past(writeData[0], 2) ? ssc_pkg::SRC_DIGITAL_POWER
                                                               : ssc_pkg::SRC_ANALOG_POWER)))
        else $error("step eleven supply monitor selection wrong");

    // automatic negative of step eleven for internal codes
    AST_ELEVEN_AUTO_NEGATIVE: assert property (
        $past(stepCfg[1].positiveInput) >= ssc_pkg::SSC_POS_FIRST_INTERNAL && !$past(reset) |->
            stepElevenRoute.negative == ssc_pkg::NEG_AUTOMATIC)
        else $error("step eleven negative select bit not ignored for internal source");

    // read straight after a write to step eleven returns the new value
    AST_ELEVEN_WRITE_READBACK: assert property (
        seqElevenWrite ##1 seqElevenRead |=> readData == ($past(writeData, 2) & ssc_pkg::SSC_WRITABLE_MASK))
        else $error("step eleven read back differs from written value");

    // the mask on the write path keeps the reserved field empty in storage
    AST_RESERVED_NEVER_STORED: assert property (
        stepCfg[0].reserved == 8'h00 && stepCfg[1].reserved == 8'h00)
        else $error("reserved bits held ones in a step word");

    // a write to any other address leaves both words alone
    AST_STRAY_WRITE_IGNORED: assert property (
        seqStrayWrite |=> stepCfg[0] == $past(stepCfg[0]) && stepCfg[1] == $past(stepCfg[1]))
        else $error("write to an unmapped address changed a step word");

    // unmapped reads answer zero rather than a stale word
    AST_STRAY_READ_ZERO: assert property (
        seqStrayRead |=> readData == 16'h0000)
        else $error("read of an unmapped address answered nonzero");

    // without a write to step ten its routing stands; the sequencer relies on that
    AST_TEN_ROUTE_HOLDS: assert property (
        !(writeStrobe && address == ssc_pkg::SSC_STEP_TEN_ADDR) |=> ##1 $stable(stepTenRoute))
        else $error("step ten routing changed without a write");

    // the same for step eleven
    AST_ELEVEN_ROUTE_HOLDS: assert property (
        !(writeStrobe && address == ssc_pkg::SSC_STEP_ELEVEN_ADDR) |=> ##1 $stable(stepElevenRoute))
        else $error("step eleven routing changed without a write");

    // limitation: routing of a word written on two back-to-back cycles
    // passes through the first value for one cycle before settling;
    // the sequencer is expected to change step words only while idle
endmodule
`default_nettype wire

// ==== bench/ssc_step_config_bench.sv ====
// self-checking testbench for the step configuration register bank
`timescale 1ns/100ps
`default_nettype none
module ssc_step_config_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic [15:0] writeData = 16'h0000;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [15:0] readData;
    ssc_pkg::ssc_route_t stepTenRoute;
    ssc_pkg::ssc_route_t stepElevenRoute;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam int CYCLE_LIMIT = 2000; // whole run needs well under 500 cycles

    ssc_step_config dut (
        .clock(clock),
        .reset(reset),
        .address(address),
        .writeData(writeData),
        .writeStrobe(writeStrobe),
        .readStrobe(readStrobe),
        .readData(readData),
        .stepTenRoute(stepTenRoute),
        .stepElevenRoute(stepElevenRoute)
    );

    // 50 ns period
    initial begin
        forever #25 clock = ~clock;
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang is cut short here and counts as a mismatch
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            errors = errors + 1;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // routing worked out from the word independently of the design's decoder
    function automatic ssc_pkg::ssc_route_t expRoute(input logic [15:0] w);
        ssc_pkg::ssc_route_t r;
        r.enable = w[15];
        r.gainFactor = (w[14:13] == 2'h0) ? 3'h1 : ((w[14:13] == 2'h1) ? 3'h2 : 3'h4);
        r.externalIndex = w[2:0];
        r.negative = w[3] ? ssc_pkg::NEG_AUTOMATIC : (w[4] ? ssc_pkg::NEG_EXTERNAL_SEVEN : ssc_pkg::NEG_ANALOG_GROUND);
        case (w[3:0])
            4'h8: r.source = ssc_pkg::SRC_TEMP_SENSOR;
            4'h9: r.source = ssc_pkg::SRC_SHORT_TO_GROUND;
            4'ha: r.source = ssc_pkg::SRC_TEST_DAC;
            4'he: r.source = ssc_pkg::SRC_ANALOG_POWER;
            4'hf: r.source = ssc_pkg::SRC_DIGITAL_POWER;
            default: r.source = w[3] ? ssc_pkg::SRC_OTHER_INTERNAL : ssc_pkg::SRC_EXTERNAL;
        endcase
        return r;
    endfunction

    // bus tasks are entered in the time step of a rising edge and leave at one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        @(negedge clock);
        chk(readData, e);
        @(posedge clock);
    endtask

    // routes follow a write one edge later than the word itself
    task automatic routesAre(input logic [15:0] ten, input logic [15:0] eleven);
        @(posedge clock);
        @(negedge clock);
        chk({4'h0, stepTenRoute}, {4'h0, expRoute(ten)});
        chk({4'h0, stepElevenRoute}, {4'h0, expRoute(eleven)});
        @(posedge clock);
    endtask

    task automatic testReset;
        @(negedge clock);
        chk({4'h0, stepTenRoute}, {4'h0, expRoute(16'h000a)});
        chk({4'h0, stepElevenRoute}, {4'h0, expRoute(16'h000b)});
        @(posedge clock);
        rd(8'h9a, 16'h000a);
        rd(8'h9b, 16'h000b);
    endtask

    // all ones then reserved-only data; read straight after each write
    task automatic testReserved;
        wr(8'h9a, 16'hffff);
        rd(8'h9a, 16'he01f);
        wr(8'h9b, 16'h1fe0);
        rd(8'h9b, 16'h0000);
        routesAre(16'he01f, 16'h0000);
    endtask

    task automatic testGain;
        for (int g = 0; g < 4; g++) begin
            wr(8'h9a, {1'b1, g[1:0], 8'h00, 1'b0, 4'h3});
            wr(8'h9b, {1'b0, ~g[1:0], 8'h00, 1'b1, 4'h6});
            routesAre({1'b1, g[1:0], 8'h00, 1'b0, 4'h3}, {1'b0, ~g[1:0], 8'h00, 1'b1, 4'h6});
        end
    endtask

    // every positive code, negative bit set on one word and clear on the other
    task automatic testPositive;
        logic [15:0] ten;
        logic [15:0] eleven;
        for (int c = 0; c < 16; c++) begin
            ten = {c[0], 2'h1, 8'h00, 1'b1, c[3:0]};
            eleven = {~c[0], 2'h2, 8'h00, 1'b0, ~c[3:0]};
            wr(8'h9a, ten);
            wr(8'h9b, eleven);
            routesAre(ten, eleven);
            rd(8'h9a, ten);
        end
    endtask

    // writes elsewhere leave the step ten word alone and unmapped reads answer zero
    task automatic testUnmapped;
        wr(8'h9a, 16'h4017);
        wr(8'h99, 16'hffff);
        wr(8'h9c, 16'h0000);
        rd(8'h9a, 16'h4017);
        rd(8'h99, 16'h0000);
        @(negedge clock);
        chk(readData, 16'h0000);
        @(posedge clock);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        testReset();
        testReserved();
        testGain();
        testPositive();
        testUnmapped();
        summarize();
    end
endmodule
`default_nettype wire
